// [logic/intc_defines.svh]
/*
 Constants of the two-level interrupt controller: register offsets,
 field positions, reset values and vector addresses.
 Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 8
`define PC_W 21
`define NSRC 8
`define NEXT 3
`define NPORT 4

`define ADR_RESET_CTL 8'h00
`define ADR_INT_CTL 8'h04
`define ADR_FLAG 8'h08
`define ADR_ENABLE 8'h0C
`define ADR_PRIO 8'h10
`define ADR_STATUS 8'h14
`define ADR_PORT_B 8'h18

`define BIT_PRIO_EN 7
`define BIT_G_HIGH 7
`define BIT_G_LOW 6
`define BIT_IN_HIGH 0
`define BIT_IN_LOW 1

`define VEC_HIGH 21'h000008
`define VEC_LOW 21'h000018
`define PERIPH_MASK 8'hF0
`define HIGH_ONLY 8'h01
`define PRIO_RST 8'hFF
`define ZERO8 8'h00
`define ZERO_PC 21'h000000

`endif

// [logic/intc_pkg.sv]
/*
 Types of the two-level interrupt controller.
 Assumes intc_defines.svh is on the include path.
*/
`default_nettype none
`include "intc_defines.svh"

package intc_pkg;
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic instrBoundary;
        logic [`PC_W-1:0] returnAddr;
        logic returnInstr;
    } core_in_t;

    typedef struct packed {
        logic take;
        logic [`PC_W-1:0] vecAddr;
        logic [`PC_W-1:0] pushAddr;
    } vec_out_t;

    typedef struct packed {
        logic [`NEXT-1:0] extS1;
        logic [`NEXT-1:0] extS2;
        logic [`NEXT-1:0] extPrev;
        logic [`NPORT-1:0] portS1;
        logic [`NPORT-1:0] portS2;
        logic [`NPORT-1:0] portLatch;
        logic [`NSRC-1:0] flag;
        logic [`NSRC-1:0] enable;
        logic [`NSRC-1:0] prio;
        logic prioEnable;
        logic gHigh;
        logic gLow;
        logic inHigh;
        logic inLow;
        vec_out_t vec;
        logic [`DATA_W-1:0] rdata;
    } intc_state_t;
endpackage

`default_nettype wire

// [logic/two_level_priority_interrupt_ctrl.sv]
/*
 Two-level priority interrupt controller with compatibility mode.
 Assumes one clock domain with the core; the core pulses instrBoundary
 when an instruction completes and returnInstr when it executes the return.
 External pins and port inputs are asynchronous; peripheral events are
 one-cycle pulses from logic on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "intc_defines.svh"

// What this block and its software do
// [R01] Priority mode: high and low vectors differ
// [R02] High request preempts running low routine
// [R03] Each source: flag, enable, priority; source0 high
// [R04] Priority scheme only when feature bit set
// [R05] High/low global enables gate by priority
// [R06] Vector once flag, enable, global set
// [R07] Compatibility: bit6 peripherals, bit7 all sources
// [R08] Compatibility: every interrupt to high vector
// [R09] Taking interrupt clears the admitting enable
// [R10] No low interrupt during high routine
// [R11] Push return address, load vector into PC
// [R12] Software clears flags before re-enabling
// [R13] Return sets the enable that was cleared
// [R14] Pin events vector within bounded latency
// [R15] Events set flags regardless of enables
// [R16] Software avoids file-to-file copy on controls
// [R17] Flags stay readable during service
// [R18] Event flags cleared only by software
// [R19] Simultaneous high and low: high first
// [R20] Vector only at instruction boundaries
module two_level_priority_interrupt_ctrl (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire intc_pkg::reg_req_t bus,
    output logic [`DATA_W-1:0] rdata,
    input wire intc_pkg::core_in_t core,
    output intc_pkg::vec_out_t vec,
    input wire logic [`NEXT-1:0] extPin,
    input wire logic [`NPORT-1:0] portPin,
    input wire logic [`NSRC-1:`NEXT+1] periphEvent
);
    import intc_pkg::*;

    intc_state_t s;
    intc_state_t next_s;

    logic [`NSRC-1:0] events;
    logic [`NSRC-1:0] pend;
    logic [`NSRC-1:0] prioEff;
    logic [`NEXT-1:0] extRise;
    logic portMis;
    logic hiReq;
    logic loReq;
    logic takeOk;

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // Edges seen only on the second synchroniser stage
    assign extRise = s.extS2 & ~s.extPrev;
    // Mismatch persists until software reads the port
    assign portMis = (s.portS2 != s.portLatch);
    assign events = {periphEvent, portMis, extRise};
    assign pend = s.flag & s.enable;
    // Source 0 has no priority bit: forced high
    assign prioEff = s.prio | `HIGH_ONLY; // [R03]

    // Compatibility: gHigh gates all, gLow gates peripherals only
    assign hiReq = s.prioEnable ?
        (s.gHigh && (|(pend & prioEff))) : // [R05] [R06]
        (s.gHigh && (|(pend & (~`PERIPH_MASK | {`NSRC{s.gLow}})))); // [R07]
    // Global high enable cleared blocks low as well
    assign loReq = s.prioEnable && s.gHigh && s.gLow && !s.inHigh
        && (|(pend & ~prioEff)); // [R04] [R05] [R10]
    // Boundary only; return cycle and the cycle after a take are skipped
    assign takeOk = core.instrBoundary && !core.returnInstr && !s.vec.take; // [R20]

    always_comb begin
        next_s = s;
        next_s.vec.take = 1'b0;
        next_s.extS1 = extPin;
        next_s.extS2 = s.extS1;
        next_s.extPrev = s.extS2;
        next_s.portS1 = portPin;
        next_s.portS2 = s.portS1;

        if (bus.wr) begin
            if (hit(bus.addr, `ADR_RESET_CTL)) begin
                next_s.prioEnable = bus.wdata[`BIT_PRIO_EN];
            end
            if (hit(bus.addr, `ADR_INT_CTL)) begin
                next_s.gHigh = bus.wdata[`BIT_G_HIGH];
                next_s.gLow = bus.wdata[`BIT_G_LOW];
            end
            if (hit(bus.addr, `ADR_FLAG)) begin
                next_s.flag = bus.wdata;
            end
            if (hit(bus.addr, `ADR_ENABLE)) begin
                next_s.enable = bus.wdata;
            end
            if (hit(bus.addr, `ADR_PRIO)) begin
                next_s.prio = bus.wdata;
            end
        end
        // Set wins over a clear in the same cycle; hardware never clears
        next_s.flag = next_s.flag | events; // [R15] [R18]

        next_s.rdata = `ZERO8;
        if (bus.rd) begin
            if (hit(bus.addr, `ADR_RESET_CTL)) begin
                next_s.rdata[`BIT_PRIO_EN] = s.prioEnable;
            end
            if (hit(bus.addr, `ADR_INT_CTL)) begin
                next_s.rdata[`BIT_G_HIGH] = s.gHigh;
                next_s.rdata[`BIT_G_LOW] = s.gLow;
            end
            if (hit(bus.addr, `ADR_FLAG)) begin
                next_s.rdata = s.flag; // [R17]
            end
            if (hit(bus.addr, `ADR_ENABLE)) begin
                next_s.rdata = s.enable;
            end
            if (hit(bus.addr, `ADR_PRIO)) begin
                next_s.rdata = prioEff;
            end
            if (hit(bus.addr, `ADR_STATUS)) begin
                next_s.rdata[`BIT_IN_HIGH] = s.inHigh;
                next_s.rdata[`BIT_IN_LOW] = s.inLow;
            end
            if (hit(bus.addr, `ADR_PORT_B)) begin
                next_s.rdata = {{(`DATA_W-`NPORT){1'b0}}, s.portS2};
                next_s.portLatch = s.portS2;
            end
        end

        // Hardware updates of the enables override a software write
        if (takeOk && hiReq) begin // [R19] [R02]
            next_s.vec.take = 1'b1;
            next_s.vec.vecAddr = `VEC_HIGH; // [R01] [R08]
            next_s.vec.pushAddr = core.returnAddr; // [R11]
            next_s.gHigh = 1'b0; // [R09]
            next_s.inHigh = 1'b1;
        end else if (takeOk && loReq) begin
            next_s.vec.take = 1'b1;
            next_s.vec.vecAddr = `VEC_LOW; // [R01]
            next_s.vec.pushAddr = core.returnAddr; // [R11]
            next_s.gLow = 1'b0; // [R09]
            next_s.inLow = 1'b1;
        end

        if (core.returnInstr) begin
            if (s.inHigh) begin
                next_s.inHigh = 1'b0;
                next_s.gHigh = 1'b1; // [R13]
            end else if (s.inLow) begin
                next_s.inLow = 1'b0;
                next_s.gLow = 1'b1; // [R13]
            end else if (!s.prioEnable) begin
                next_s.gHigh = 1'b1; // [R13]
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.prio <= `PRIO_RST;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign vec = s.vec;

    a_high_vector: // [R01]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.vec.take && $past(s.prioEnable) && $past(hiReq))
        |-> s.vec.vecAddr == `VEC_HIGH)
    else $error("high request did not go to high vector");

    a_low_vector: // [R01]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.vec.take && $past(s.prioEnable) && !$past(hiReq))
        |-> s.vec.vecAddr == `VEC_LOW)
    else $error("low request did not go to low vector");

    a_compat_vector: // [R08]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.vec.take && !$past(s.prioEnable)) |-> s.vec.vecAddr == `VEC_HIGH)
    else $error("compatibility take not at high vector");

    a_preempt_low: // [R02]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (takeOk && hiReq && s.inLow) |=> (s.vec.take && s.inHigh && s.inLow))
    else $error("high request did not preempt low routine");

    a_enable_clear: // [R09]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (takeOk && hiReq) |=> (!s.gHigh && s.vec.take))
    else $error("admitting enable not cleared on take");

    a_no_low_in_high: // [R10]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (s.vec.take && s.vec.vecAddr == `VEC_LOW) |-> !$past(s.inHigh))
    else $error("low interrupt taken during high routine");

    a_push_return: // [R11]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        s.vec.take |-> (s.vec.pushAddr == $past(core.returnAddr)))
    else $error("pushed address is not the return address");

    a_return_restore: // [R13]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (core.returnInstr && s.inHigh) |=> (s.gHigh && !s.inHigh))
    else $error("return did not restore high enable");

    a_pin_latency: // [R14]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(s.extS1[0]) |-> ##[2:3] s.flag[0])
    else $error("pin event flag too late");

    a_event_sets: // [R15]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (events != `ZERO8) |=> ((s.flag & $past(events)) == $past(events)))
    else $error("event did not set its flag");

    a_flag_sticky: // [R18]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !(bus.wr && hit(bus.addr, `ADR_FLAG))
        |=> ((s.flag & $past(s.flag)) == $past(s.flag)))
    else $error("flag cleared without software write");

    a_take_boundary: // [R20]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        s.vec.take |-> ($past(core.instrBoundary) && !$past(core.returnInstr)))
    else $error("vector taken off an instruction boundary");

    a_take_pulse: // [R11]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        s.vec.take |=> !s.vec.take)
    else $error("take pulse longer than one cycle");

    a_low_clear: // [R09]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (takeOk && !hiReq && loReq) |=> (!s.gLow && s.inLow && s.vec.take))
    else $error("low enable not cleared on low take");

    a_vec_hold: // [R11]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !s.vec.take |-> $stable(s.vec.vecAddr))
    else $error("vector address changed without a take");

    a_push_hold: // [R11]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !s.vec.take |-> $stable(s.vec.pushAddr))
    else $error("pushed address changed without a take");

    a_no_take_ret: // [R20]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        core.returnInstr |=> !s.vec.take)
    else $error("take after a return cycle");

    a_no_take_mid: // [R20]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !core.instrBoundary |=> !s.vec.take)
    else $error("take without instruction boundary");

    a_compat_gate: // [R07]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (!s.prioEnable && !s.gLow && ((s.flag & s.enable & ~`PERIPH_MASK) == `ZERO8))
        |-> !hiReq)
    else $error("peripheral request passed a closed group enable");

    a_global_off: // [R05]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !s.gHigh |-> !(hiReq || loReq))
    else $error("request with global high enable clear");

    a_low_gate: // [R05]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !s.gLow |-> !loReq)
    else $error("low request with global low enable clear");

    a_enable_block: // [R06]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        ((s.flag & s.enable) == `ZERO8) |-> !(hiReq || loReq))
    else $error("request without enabled flag");

    a_src0_high: // [R03]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        prioEff[0])
    else $error("source zero not high priority");

    a_low_restore: // [R13]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (core.returnInstr && !s.inHigh && s.inLow) |=> (s.gLow && !s.inLow))
    else $error("return did not restore low enable");

    a_compat_restore: // [R13]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (core.returnInstr && !s.inHigh && !s.inLow && !s.prioEnable) |=> s.gHigh)
    else $error("return did not restore all-source enable");

    a_read_idle: // [R17]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !bus.rd |=> (s.rdata == `ZERO8))
    else $error("read data not zero outside read cycle");

    a_flag_readback: // [R17]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (bus.rd && hit(bus.addr, `ADR_FLAG)) |=> (s.rdata == $past(s.flag)))
    else $error("flag read does not show flags");

    a_high_first: // [R19]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (takeOk && hiReq && loReq) |=> (s.vec.vecAddr == `VEC_HIGH))
    else $error("low taken before pending high");

    a_default_off: // [R04]
    assert property (@(posedge sys_clk) disable iff (!rstn)
        !s.prioEnable |-> !loReq)
    else $error("low level active with priority disabled");
endmodule // two_level_priority_interrupt_ctrl

`default_nettype wire

// [bench/core_model.sv]
/*
 Behavioural core on the far side of the controller: ends an instruction
 every fourth cycle and executes the return when the bench asks.
 Assumes intc_pkg is compiled first and one clock shared with the block.
*/
`timescale 1ns/1ns
`default_nettype none

module core_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic doRet,
    input wire logic [20:0] retAddr,
    output var intc_pkg::core_in_t core
);
    import intc_pkg::*;
    logic [1:0] cnt;

    // Return cycle never doubles as a boundary, so only one request at a time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 2'h0;
            core <= '0;
        end else begin
            cnt <= cnt + 2'h1;
            core.instrBoundary <= (cnt == 2'h3) && !doRet;
            core.returnAddr <= retAddr;
            core.returnInstr <= doRet;
        end
    end
endmodule // core_model

`default_nettype wire

// [bench/tb.sv]
/*
 Self-checking bench of the interrupt controller.
 Assumes the design files and core_model are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "intc_defines.svh"

module tb;
    import intc_pkg::*;
    logic sysClk, rstn, doRet;
    reg_req_t bus;
    logic [7:0] rdata;
    core_in_t core;
    vec_out_t vec;
    logic [2:0] extPin;
    logic [3:0] portPin, periph;
    logic [20:0] retAddr;
    int badCount, checkCount;

    two_level_priority_interrupt_ctrl i_dut (.sys_clk(sysClk), .rstn(rstn), .bus(bus),
        .rdata(rdata), .core(core), .vec(vec), .extPin(extPin), .portPin(portPin),
        .periphEvent(periph));
    core_model i_core (.sys_clk(sysClk), .rstn(rstn), .doRet(doRet), .retAddr(retAddr),
        .core(core));

    task automatic giveVerdict;
        if (badCount == 0 && checkCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One register per write, never a copy between controls
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sysClk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge sysClk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sysClk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge sysClk);
        bus.rd <= 1'b0;
        #1 chk({13'h0, rdata}, {13'h0, exp});
    endtask

    task automatic ev(input logic [3:0] m);
        @(posedge sysClk);
        periph <= m;
        @(posedge sysClk);
        periph <= 4'h0;
    endtask

    task automatic waitTake(input logic [20:0] v);
        int n;
        n = 0;
        @(posedge sysClk);
        #1;
        while (vec.take !== 1'b1 && n < 40) begin
            @(posedge sysClk);
            #1 n++;
        end
        chk({20'h0, vec.take}, 21'h1);
        chk(vec.vecAddr, v);
        chk(vec.pushAddr, retAddr);
    endtask

    task automatic noTake;
        repeat (12) begin
            @(posedge sysClk);
            #1 chk({20'h0, vec.take}, 21'h0);
        end
    endtask

    task automatic ret;
        @(posedge sysClk);
        doRet <= 1'b1;
        @(posedge sysClk);
        doRet <= 1'b0;
    endtask

    task automatic testReset;
        rd(8'h10, 8'hFF);
        rd(8'h00, 8'h00);
        rd(8'h1C, 8'h00);
        @(posedge sysClk);
        extPin <= 3'h1;
        repeat (5) @(posedge sysClk);
        rd(8'h08, 8'h01);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'h00);
        @(posedge sysClk);
        portPin <= 4'h5;
        repeat (5) @(posedge sysClk);
        rd(8'h08, 8'h08);
        rd(8'h18, 8'h05);
        wr(8'h08, 8'h00);
        rd(8'h08, 8'h00);
    endtask

    task automatic testCompat;
        @(posedge sysClk);
        retAddr <= 21'h000123;
        ev(4'h1);
        rd(8'h08, 8'h10);
        wr(8'h0C, 8'h10);
        wr(8'h04, 8'h80);
        noTake();
        wr(8'h04, 8'hC0);
        waitTake(`VEC_HIGH);
        rd(8'h04, 8'h40);
        wr(8'h08, 8'h00);
        ret();
        rd(8'h04, 8'hC0);
    endtask

    task automatic testPrio;
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h80);
        wr(8'h10, 8'hEF);
        wr(8'h0C, 8'h30);
        retAddr <= 21'h000456;
        wr(8'h04, 8'hC0);
        ev(4'h1);
        waitTake(`VEC_LOW);
        rd(8'h04, 8'h80);
        ev(4'h2);
        waitTake(`VEC_HIGH);
        rd(8'h14, 8'h03);
        rd(8'h08, 8'h30);
        wr(8'h08, 8'h00);
        ret();
        ret();
        rd(8'h04, 8'hC0);
        ev(4'h3);
        waitTake(`VEC_HIGH);
        noTake();
        wr(8'h08, 8'h10);
        ret();
        waitTake(`VEC_LOW);
    endtask

    initial begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end

    initial begin
        #50000;
        badCount++;
        giveVerdict();
    end

    initial begin
        badCount = 0;
        checkCount = 0;
        rstn = 1'b0;
        bus = '0;
        doRet = 1'b0;
        extPin = 3'h0;
        portPin = 4'h0;
        periph = 4'h0;
        retAddr = 21'h000000;
        repeat (5) @(posedge sysClk);
        rstn <= 1'b1;
        testReset();
        testCompat();
        testPrio();
        giveVerdict();
    end
endmodule // tb

`default_nettype wire
